//--- hdl/pps_pkg.sv
package pps_pkg;

    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_PORT_D = 8'h08;
    localparam logic [7:0] IDX_PORT_E = 8'h09;
    localparam logic [7:0] IDX_DIR_D = 8'h88;
    localparam logic [7:0] IDX_DIR_E = 8'h89;
    localparam logic [7:0] IDX_ANALOG = 8'h9F;
    localparam logic [ADDR_W-1:0] A_PORT_D = {IDX_PORT_D, 2'h0};
    localparam logic [ADDR_W-1:0] A_PORT_E = {IDX_PORT_E, 2'h0};
    localparam logic [ADDR_W-1:0] A_DIR_D = {IDX_DIR_D, 2'h0};
    localparam logic [ADDR_W-1:0] A_DIR_E = {IDX_DIR_E, 2'h0};
    localparam logic [ADDR_W-1:0] A_ANALOG = {IDX_ANALOG, 2'h0};

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_IBF = 7;
    localparam int BIT_OBF = 6;
    localparam int BIT_INPUT_OVERFLOW_FLAG = 5;
    localparam int BIT_MODE = 4;
    localparam int BIT_FMT = 7;
    localparam int PIN_RD = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_SEL = 2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_DIR_D = 8'hFF;
    localparam logic [2:0] RST_DIR_E = 3'h7;
    localparam logic [7:0] RST_LATCH_D = 8'h00;
    localparam logic [2:0] RST_LATCH_E = 3'h0;
    localparam logic [3:0] RST_CFG = 4'h0;

    // config field codes that make the control pins digital
    localparam logic [3:0] CFG_DIGITAL_A = 4'h6;
    localparam logic [3:0] CFG_DIGITAL_B = 4'h7;

    // ----------------------------------------
    // clock phases
    // ----------------------------------------
    localparam int PHASES = 4;
    localparam int PH_Q2 = 1;
    localparam int PH_Q4 = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACTIVE = 2'h1,
        ST_WAIT_Q2 = 2'h3,
        ST_WAIT_Q4 = 2'h2
    } pps_xfer_state_t;

endpackage

//--- hdl/pps_phase_if.sv
interface pps_phase_if;
    logic q2;
    logic q4;
    modport gen (output q2, output q4);
    modport use_ph (input q2, input q4);
endinterface

//--- hdl/pps_phase_gen.sv
module pps_phase_gen #(
    parameter int PHASES = pps_pkg::PHASES
) (
    input wire logic clock_in,   // core clock
    input wire logic sys_rst_in, // sync reset, active high
    pps_phase_if.gen ph          // phase strobes
);

    localparam int CW = $clog2(PHASES);

    generate
        if (PHASES < 4) begin : g_chk
            $error("PHASES must be at least 4");
        end
    endgenerate

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // ----------------------------------------
    // phase counter: one phase per clock
    // ----------------------------------------
    assign cnt_d = (cnt_q == CW'(PHASES - 1)) ? '0 : cnt_q + CW'(1);

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign ph.q2 = (cnt_q == CW'(pps_pkg::PH_Q2));
    assign ph.q4 = (cnt_q == CW'(pps_pkg::PH_Q4));

endmodule

//--- hdl/pps_parallel_port.sv
// Behaviour
// [RULE1] byte port pins each have direction bits
// [RULE2] control direction bits: 1 input, 0 output
// [RULE3] mode bit 4 selects slave or GPIO
// [RULE4] slave mode: control pins are strobes
// [RULE5] software sets strobes input and digital
// [RULE6] analog control pins read as zero
// [RULE7] direction bits drive control pins always
// [RULE8] after reset control pins analog, read zero
// [RULE9] select and read low drive output latch
// [RULE10] select and write low capture pins
// [RULE11] select is active low, gates strobes
// [RULE12] bit 7 input full flag
// [RULE13] bit 6 output full flag
// [RULE14] bit 5 overflow, software clears
// [RULE15] bit 3 reads zero, ignores writes
// [RULE16] status register resets to 0000 -111
// [RULE17] byte direction register resets all ones
// [RULE18] input full set at Q4 after Q2
// [RULE19] input full clears on latch read
// [RULE20] output full clears on external read
// [RULE21] outside slave mode full flags held zero
// [RULE22] master holds select, never both strobes
//
// Our own choice: register access over Avalon-MM.
module pps_parallel_port #(
    parameter int DATA_W = 8,
    parameter int CTRL_W = 3
) (
    input wire logic clock_in,                  // core clock, 250 MHz
    input wire logic sys_rst_in,                // sync reset, active high
    input wire logic [9:0] avs_address_in,      // avalon byte address
    input wire logic avs_read_in,               // avalon read
    input wire logic avs_write_in,              // avalon write
    input wire logic [31:0] avs_writedata_in,   // avalon write data
    input wire logic [3:0] avs_byteenable_in,   // avalon byte enables
    output logic [31:0] avs_readdata_out,       // avalon read data
    output logic avs_waitrequest_out,           // avalon wait
    input wire logic [7:0] byte_port_pins_in,   // byte port pin levels
    output logic [7:0] byte_port_pins_out,      // byte port drive value
    output logic [7:0] byte_port_pins_oe_out,   // byte port drive enable
    input wire logic [2:0] ctrl_pins_in,        // control pin levels
    output logic [2:0] ctrl_pins_out,           // control pin drive value
    output logic [2:0] ctrl_pins_oe_out,        // control pin drive enable
    output logic [2:0] analog_select_out,       // control pins analog
    output logic slave_port_mode_sel_out,       // slave mode active
    output logic transfer_done_irq_flag_out     // transfer done pulse
);

    generate
        if (DATA_W != 8 || CTRL_W != 3) begin : g_chk
            $error("port widths are fixed at 8 and 3");
        end
    endgenerate

    // ----------------------------------------
    // phase strobes
    // ----------------------------------------
    pps_phase_if ph_if ();

    pps_phase_gen #(
        .PHASES(pps_pkg::PHASES)
    ) u_phase (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .ph(ph_if)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] latch_d_q;
    logic [7:0] latch_d_d;
    logic [2:0] latch_e_q;
    logic [2:0] latch_e_d;
    logic [7:0] dir_d_q;
    logic [7:0] dir_d_d;
    logic [2:0] dir_e_q;
    logic [2:0] dir_e_d;
    logic mode_q;
    logic mode_d;
    logic ibf_q;
    logic ibf_d;
    logic obf_q;
    logic obf_d;
    logic input_overflow_flag_q;
    logic input_overflow_flag_d;
    logic fmt_q;
    logic fmt_d;
    logic [3:0] cfg_q;
    logic [3:0] cfg_d;
    logic [7:0] in_latch_q;
    logic [7:0] in_latch_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic done_q;
    logic done_d;
    logic is_wr_q;
    logic is_wr_d;
    pps_pkg::pps_xfer_state_t st_q;
    pps_pkg::pps_xfer_state_t st_d;

    // ----------------------------------------
    // bus handshake: one wait state per access
    // ----------------------------------------
    wire req = avs_read_in | avs_write_in;
    wire commit = req & ack_q;
    wire lane0 = avs_byteenable_in[0];
    wire sw_wr = commit & avs_write_in & lane0;
    wire sw_rd = commit & avs_read_in;
    wire [7:0] wd = avs_writedata_in[7:0];

    assign ack_d = req & ~ack_q;
    assign avs_waitrequest_out = req & ~ack_q;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire hit_pd = (avs_address_in == pps_pkg::A_PORT_D);
    wire hit_pe = (avs_address_in == pps_pkg::A_PORT_E);
    wire hit_dd = (avs_address_in == pps_pkg::A_DIR_D);
    wire hit_de = (avs_address_in == pps_pkg::A_DIR_E);
    wire hit_an = (avs_address_in == pps_pkg::A_ANALOG);

    wire wr_pd = sw_wr & hit_pd;
    wire wr_pe = sw_wr & hit_pe;
    wire wr_dd = sw_wr & hit_dd;
    wire wr_de = sw_wr & hit_de;
    wire wr_an = sw_wr & hit_an;
    wire rd_pd = sw_rd & hit_pd;

    // ----------------------------------------
    // analog selection of control pins
    // ----------------------------------------
    wire cfg_digital = (cfg_q == pps_pkg::CFG_DIGITAL_A) |
                       (cfg_q == pps_pkg::CFG_DIGITAL_B);
    // after reset the field is zero, so all three pins are analog
    wire [2:0] analog_mask = cfg_digital ? 3'h0 : 3'h7; // [RULE8]

    assign analog_select_out = analog_mask;
    assign slave_port_mode_sel_out = mode_q;

    // analog pins read as zero in the data register
    wire [2:0] pe_read = ctrl_pins_in & ~analog_mask; // [RULE6] [RULE8]

    // an analog pin has no digital input, so as a strobe it is idle
    wire [2:0] ctrl_eff = ctrl_pins_in | analog_mask;

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    // strobes count only while select is low
    wire sel_low = mode_q & ~ctrl_eff[pps_pkg::PIN_SEL]; // [RULE4] [RULE11]
    wire rd_act = sel_low & ~ctrl_eff[pps_pkg::PIN_RD]; // [RULE9]
    wire wr_act = sel_low & ~ctrl_eff[pps_pkg::PIN_WR]; // [RULE10]

    // the master never lowers both strobes; write is taken first if it does
    wire wr_start = (st_q == pps_pkg::ST_IDLE) & wr_act; // [RULE22]
    wire rd_start = (st_q == pps_pkg::ST_IDLE) & rd_act & ~wr_act;

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        is_wr_d = is_wr_q;
        done_d = 1'b0;
        case (st_q)
            pps_pkg::ST_IDLE: begin
                if (wr_start) begin
                    st_d = pps_pkg::ST_ACTIVE;
                    is_wr_d = 1'b1;
                end else if (rd_start) begin
                    st_d = pps_pkg::ST_ACTIVE;
                    is_wr_d = 1'b0;
                end
            end
            pps_pkg::ST_ACTIVE: begin
                // either select or strobe high ends the transfer
                if (is_wr_q ? ~wr_act : ~rd_act) begin
                    st_d = pps_pkg::ST_WAIT_Q2;
                end
            end
            pps_pkg::ST_WAIT_Q2: begin
                if (ph_if.q2) begin
                    st_d = pps_pkg::ST_WAIT_Q4; // [RULE18]
                end
            end
            pps_pkg::ST_WAIT_Q4: begin
                if (ph_if.q4) begin
                    st_d = pps_pkg::ST_IDLE;
                    done_d = 1'b1; // [RULE18]
                end
            end
            default: begin
                st_d = pps_pkg::ST_IDLE;
            end
        endcase
        // leaving slave mode abandons a transfer in flight
        if (!mode_q) begin
            st_d = pps_pkg::ST_IDLE;
            done_d = 1'b0;
        end
    end

    wire set_ibf = done_d & is_wr_q;

    // ----------------------------------------
    // input latch
    // ----------------------------------------
    // the pins are followed for as long as select and the write strobe are both low
    assign in_latch_d = wr_act ? byte_port_pins_in : in_latch_q; // [RULE10]

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // set by the sequencer wins over a clearing read
    assign ibf_d = !mode_q ? 1'b0 : // [RULE21]
                   set_ibf ? 1'b1 : // [RULE12] [RULE18]
                   (rd_pd ? 1'b0 : ibf_q); // [RULE19]

    // a firmware write wins over an external read starting with it
    assign obf_d = !mode_q ? 1'b0 : // [RULE21]
                   wr_pd ? 1'b1 : // [RULE13]
                   (rd_start ? 1'b0 : obf_q); // [RULE20]

    // overflow survives mode changes; hardware set wins over clear
    wire input_overflow_flag_set = wr_start & ibf_q; // [RULE14]
    assign input_overflow_flag_d = input_overflow_flag_set | (wr_de ? wd[pps_pkg::BIT_INPUT_OVERFLOW_FLAG] : input_overflow_flag_q); // [RULE14] [RULE21]

    // ----------------------------------------
    // software writable fields
    // ----------------------------------------
    assign latch_d_d = wr_pd ? wd : latch_d_q;
    assign latch_e_d = wr_pe ? wd[2:0] : latch_e_q;
    assign dir_d_d = wr_dd ? wd : dir_d_q; // [RULE1]
    assign dir_e_d = wr_de ? wd[2:0] : dir_e_q; // [RULE2]
    assign mode_d = wr_de ? wd[pps_pkg::BIT_MODE] : mode_q; // [RULE3]
    assign fmt_d = wr_an ? wd[pps_pkg::BIT_FMT] : fmt_q;
    assign cfg_d = wr_an ? wd[3:0] : cfg_q;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // bit 3 of the status register has no storage and reads zero
    wire [7:0] de_read = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0, dir_e_q}; // [RULE15]
    wire [7:0] pd_read = mode_q ? in_latch_q : byte_port_pins_in;
    wire [7:0] an_read = {fmt_q, 3'h0, cfg_q};

    wire [7:0] rd_mux = hit_pd ? pd_read :
                        hit_pe ? {5'h00, pe_read} :
                        hit_dd ? dir_d_q :
                        hit_de ? de_read :
                        hit_an ? an_read : 8'h00;

    // read data is sampled while waitrequest is high, held after
    assign rdata_d = (avs_read_in & ~ack_q) ? {24'h000000, rd_mux} : rdata_q;
    assign avs_readdata_out = rdata_q;

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // byte port: slave mode ignores the direction register
    assign byte_port_pins_out = latch_d_q; // [RULE9]
    assign byte_port_pins_oe_out = mode_q ? {8{rd_act}} : ~dir_d_q; // [RULE1] [RULE9]

    // control pins keep their direction bits in every mode
    assign ctrl_pins_out = latch_e_q;
    assign ctrl_pins_oe_out = ~dir_e_q; // [RULE2] [RULE7]

    assign transfer_done_irq_flag_out = done_q;

    // ----------------------------------------
    // state flops
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ibf_q <= 1'b0; // [RULE16]
            obf_q <= 1'b0; // [RULE16]
            input_overflow_flag_q <= 1'b0; // [RULE16]
            mode_q <= 1'b0; // [RULE16]
            dir_e_q <= pps_pkg::RST_DIR_E; // [RULE16]
        end else begin
            ibf_q <= ibf_d;
            obf_q <= obf_d;
            input_overflow_flag_q <= input_overflow_flag_d;
            mode_q <= mode_d;
            dir_e_q <= dir_e_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            dir_d_q <= pps_pkg::RST_DIR_D; // [RULE17]
            latch_d_q <= pps_pkg::RST_LATCH_D;
            latch_e_q <= pps_pkg::RST_LATCH_E;
            in_latch_q <= pps_pkg::RST_LATCH_D;
        end else begin
            dir_d_q <= dir_d_d;
            latch_d_q <= latch_d_d;
            latch_e_q <= latch_e_d;
            in_latch_q <= in_latch_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fmt_q <= 1'b0;
            cfg_q <= pps_pkg::RST_CFG; // [RULE8]
        end else begin
            fmt_q <= fmt_d;
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_q <= pps_pkg::ST_IDLE;
            is_wr_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            is_wr_q <= is_wr_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

endmodule

//--- bench/pps_checker.sv
module pps_checker (
    input wire logic clock_in,                  // core clock
    input wire logic sys_rst_in,                // sync reset
    input wire logic avs_read_in,               // avalon read
    input wire logic avs_write_in,              // avalon write
    input wire logic [31:0] avs_readdata_out,   // avalon read data
    input wire logic avs_waitrequest_out,       // avalon wait
    input wire logic [7:0] byte_port_pins_oe_out, // byte drive enable
    input wire logic [2:0] ctrl_pins_in,        // control pin levels
    input wire logic [2:0] ctrl_pins_oe_out,    // control drive enable
    input wire logic [2:0] analog_select_out,   // control pins analog
    input wire logic slave_port_mode_sel_out,   // slave mode
    input wire logic transfer_done_irq_flag_out // done pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // bus and slave port relations
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    wire req = avs_read_in | avs_write_in;
    wire dig = slave_port_mode_sel_out && analog_select_out == 3'h0;
    wire done = transfer_done_irq_flag_out;

    a_wait_one: assert property ($rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("wait state count wrong");
    a_wait_idle: assert property (!req |-> !avs_waitrequest_out)
        else $error("wait without request");
    a_upper_zero: assert property (avs_read_in && !avs_waitrequest_out |->
        avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
    a_read_drive: assert property (dig && ctrl_pins_in == 3'h2 |->
        byte_port_pins_oe_out == 8'hFF) else $error("byte port not driven on read");
    a_desel_quiet: assert property (dig && ctrl_pins_in[2] |->
        byte_port_pins_oe_out == 8'h00) else $error("byte port driven while deselected");
    a_analog_idle: assert property (slave_port_mode_sel_out &&
        analog_select_out == 3'h7 |-> byte_port_pins_oe_out == 8'h00)
        else $error("analog strobe acted");
    a_done_single: assert property (done |=> !done)
        else $error("done pulse too long");
    a_done_bound: assert property (dig && $rose(ctrl_pins_in[1]) &&
        !ctrl_pins_in[2] |-> ##[1:10] done) else $error("write completion late");
    a_done_mode: assert property (done |-> $past(slave_port_mode_sel_out, 2))
        else $error("done outside slave mode");
    a_reset_state: assert property ($fell(sys_rst_in) |->
        analog_select_out == 3'h7 &&
        !slave_port_mode_sel_out && ctrl_pins_oe_out == 3'h0)
        else $error("reset state wrong");
    c_done: cover property (done);
    c_drive: cover property (byte_port_pins_oe_out == 8'hFF);
    c_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule

bind pps_parallel_port pps_checker u_chk (.clock_in, .sys_rst_in, .avs_read_in,
    .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .byte_port_pins_oe_out,
    .ctrl_pins_in, .ctrl_pins_oe_out, .analog_select_out, .slave_port_mode_sel_out,
    .transfer_done_irq_flag_out);

//--- bench/pps_ext_master.sv
module pps_ext_master (
    input wire logic clock_in,             // core clock
    input wire logic [7:0] dut_byte_in,    // device byte drive
    input wire logic [7:0] dut_byte_oe_in, // device byte enable
    input wire logic [2:0] dut_ctrl_in,    // device control drive
    input wire logic [2:0] dut_ctrl_oe_in, // device control enable
    output logic [7:0] byte_level_out,     // resolved byte wire
    output logic [2:0] ctrl_level_out      // resolved control wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] data_q = 8'h00;
    logic drive_q = 1'b0;
    logic [7:0] float_q = 8'h55;
    logic [2:0] strobe_q = 3'h7;
    // an undriven byte wire shows a pattern that changes every cycle
    always @(posedge clock_in) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            byte_level_out[i] = dut_byte_oe_in[i] ? dut_byte_in[i] :
                (drive_q ? data_q[i] : float_q[i]);
        end
        for (int i = 0; i < 3; i++) begin
            ctrl_level_out[i] = dut_ctrl_oe_in[i] ? dut_ctrl_in[i] : strobe_q[i];
        end
    end
    task automatic ext_write(input logic [7:0] d, input logic sel);
        @(posedge clock_in);
        strobe_q[2] <= ~sel;
        data_q <= d;
        drive_q <= 1'b1;
        @(posedge clock_in);
        strobe_q[1] <= 1'b0;
        repeat (2) @(posedge clock_in);
        strobe_q[1] <= 1'b1;
        @(posedge clock_in);
        strobe_q[2] <= 1'b1;
        drive_q <= 1'b0;
        repeat (10) @(posedge clock_in);
    endtask
    task automatic ext_read(output logic [7:0] q);
        @(posedge clock_in);
        strobe_q[2] <= 1'b0;
        @(posedge clock_in);
        strobe_q[0] <= 1'b0;
        repeat (2) @(posedge clock_in);
        q = byte_level_out;
        strobe_q[0] <= 1'b1;
        @(posedge clock_in);
        strobe_q[2] <= 1'b1;
        repeat (10) @(posedge clock_in);
    endtask
endmodule

//--- bench/pps_parallel_port_tb.sv
module pps_parallel_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [9:0] avs_address_in = 10'h000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out, rd;
    logic avs_waitrequest_out, mode_out, done_out;
    logic [7:0] byte_out, byte_oe, byte_level, rx;
    logic [2:0] ctrl_out, ctrl_oe, ctrl_level, analog_sel;
    int n_mismatch = 0;
    int samples_checked = 0;

    pps_parallel_port u_dut (.clock_in, .sys_rst_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .byte_port_pins_in(byte_level), .byte_port_pins_out(byte_out),
        .byte_port_pins_oe_out(byte_oe), .ctrl_pins_in(ctrl_level), .ctrl_pins_out(ctrl_out),
        .ctrl_pins_oe_out(ctrl_oe), .analog_select_out(analog_sel),
        .slave_port_mode_sel_out(mode_out), .transfer_done_irq_flag_out(done_out));
    pps_ext_master u_ext (.clock_in, .dut_byte_in(byte_out), .dut_byte_oe_in(byte_oe),
        .dut_ctrl_in(ctrl_out), .dut_ctrl_oe_in(ctrl_oe), .byte_level_out(byte_level),
        .ctrl_level_out(ctrl_level));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        // hold the request until waitrequest is sampled low at a rising edge
        do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial forever #2 clock_in = ~clock_in;
    initial begin
        repeat (20000) @(posedge clock_in);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rchk(pps_pkg::A_DIR_E, 8'h07);
        rchk(pps_pkg::A_DIR_D, 8'hFF);
        rchk(pps_pkg::A_ANALOG, 8'h00);
        rchk(pps_pkg::A_PORT_E, 8'h00);
        $display("test reset done");
        bus(1'b1, pps_pkg::A_DIR_D, 8'h0F);
        bus(1'b1, pps_pkg::A_PORT_D, 8'hA5);
        avs_byteenable_in <= 4'h0;
        bus(1'b1, pps_pkg::A_DIR_D, 8'h00);
        avs_byteenable_in <= 4'hF;
        @(negedge clock_in);
        chk({16'h0, byte_oe, byte_out}, 32'h0000F0A5);
        rchk(10'h3FC, 8'h00);
        bus(1'b1, pps_pkg::A_DIR_E, 8'h00);
        bus(1'b1, pps_pkg::A_PORT_E, 8'h05);
        @(negedge clock_in);
        chk({29'h0, ctrl_oe}, 32'h7);
        rchk(pps_pkg::A_PORT_E, 8'h00);
        bus(1'b1, pps_pkg::A_ANALOG, 8'h06);
        rchk(pps_pkg::A_PORT_E, 8'h05);
        bus(1'b1, pps_pkg::A_DIR_E, 8'hCF);
        rchk(pps_pkg::A_DIR_E, 8'h07);
        $display("test gpio done");
        bus(1'b1, pps_pkg::A_DIR_E, 8'h17);
        bus(1'b1, pps_pkg::A_PORT_D, 8'h5A);
        rchk(pps_pkg::A_DIR_E, 8'h57);
        u_ext.ext_write(8'hC3, 1'b0);
        rchk(pps_pkg::A_DIR_E, 8'h57);
        u_ext.ext_write(8'hC3, 1'b1);
        rchk(pps_pkg::A_DIR_E, 8'hD7);
        u_ext.ext_write(8'h99, 1'b1);
        rchk(pps_pkg::A_DIR_E, 8'hF7);
        rchk(pps_pkg::A_PORT_D, 8'h99);
        rchk(pps_pkg::A_DIR_E, 8'h77);
        u_ext.ext_read(rx);
        chk({24'h0, rx}, 32'h5A);
        rchk(pps_pkg::A_DIR_E, 8'h37);
        u_ext.ext_write(8'h11, 1'b1);
        bus(1'b1, pps_pkg::A_DIR_E, 8'h27);
        rchk(pps_pkg::A_DIR_E, 8'h27);
        bus(1'b1, pps_pkg::A_DIR_E, 8'h07);
        rchk(pps_pkg::A_DIR_E, 8'h07);
        $display("test slave done");
        // strobes on analog pins count as idle, so the output byte stays full
        bus(1'b1, pps_pkg::A_ANALOG, 8'h00);
        bus(1'b1, pps_pkg::A_DIR_E, 8'h17);
        bus(1'b1, pps_pkg::A_PORT_D, 8'h3C);
        u_ext.ext_read(rx);
        rchk(pps_pkg::A_DIR_E, 8'h57);
        $display("test analog strobes done");
        print_verdict();
    end
endmodule
